// File: shared/ext_trig_map.svh
// register offsets, reset values and timing counts of the external trigger block
`ifndef EXT_TRIG_MAP_SVH
`define EXT_TRIG_MAP_SVH

`define EXT_CFG_LOW_ADR   32'h5600_0088
`define EXT_CFG_MID_ADR   32'h5600_008c
`define EXT_CFG_HIGH_ADR  32'h5600_0090
`define EXT_IRQ_STAT_ADR  32'h5600_00b0
`define EXT_IRQ_CLR_ADR   32'h5600_00b4
`define EXT_IRQ_EN_ADR    32'h5600_00b8

`define EXT_CFG_RST       32'h0000_0000
`define EXT_IRQ_RST       16'h0000
`define EXT_CFG_LOW_MASK  32'h7777_7777

`define EXT_FIELD_STEP    4
`define EXT_MODE_LSB      0
`define EXT_MODE_MSB      2
`define EXT_FILT_BIT      3

`define EXT_FILT_NS       40
`define EXT_CLK_NS        100
`define EXT_FILT_CYC      ((`EXT_FILT_NS + `EXT_CLK_NS - 1) / `EXT_CLK_NS)

`endif

// File: shared/ext_trig_pkg.sv
// types shared by the external trigger block
package ext_trig_pkg;
   typedef logic [31:0] word_t;
   typedef logic [2:0]  trig_mode_t;
   typedef enum logic [2:0] {
      KIND_LOW  = 3'b000,
      KIND_HIGH = 3'b001,
      KIND_FALL = 3'b010,
      KIND_RISE = 3'b011,
      KIND_BOTH = 3'b100
   } trig_kind_e;
endpackage

// File: shared/line_cfg_if.sv
// per-line trigger setup and request between controller and detector
`timescale 1ns/1ps
interface line_cfg_if;
   ext_trig_pkg::trig_mode_t mode;
   logic                     filt_on;
   logic                     req;
   modport ctrl     (output mode, output filt_on, input req);
   modport detector (input mode, input filt_on, output req);
endinterface

// File: design/trig_line_detect.sv
// one external line: synchroniser, noise filter, trigger decode
`timescale 1ns/1ps
`include "ext_trig_map.svh"
module trig_line_detect #(
   parameter int FILT_CYC = `EXT_FILT_CYC
) (
   input  wire logic           core_clk,
   input  wire logic           rst_b,
   input  wire logic           pin,
   line_cfg_if.detector        cfg
);
   import ext_trig_pkg::*;

   localparam int CW = $clog2(FILT_CYC + 1) + 1;

   function automatic trig_kind_e decode(input trig_mode_t m);
      trig_kind_e k;
      k = KIND_LOW;
      unique casez (m)
         3'b000: k = KIND_LOW;
         3'b001: k = KIND_HIGH;
         3'b01?: k = KIND_FALL;
         3'b10?: k = KIND_RISE;
         3'b11?: k = KIND_BOTH;
      endcase
      return k;
   endfunction

   ///////////////////////////////////////////////////////////////////////////
   logic [2:0]    sync_q,  sync_d;
   logic          clean_q, clean_d;
   logic          filt_q,  filt_d;
   logic [CW-1:0] cnt_q,   cnt_d;
   logic          prev_q,  prev_d;
   logic          level;
   logic          req_d;
   logic          req_q;

   always_comb begin
      sync_d  = {sync_q[1:0], pin};
      // change accepted once second and third stage agree
      clean_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : clean_q;
      filt_d  = filt_q;
      cnt_d   = '0;
      if (clean_q != filt_q) begin
         // new level accepted after FILT_CYC differing cycles in a row
         if (cnt_q >= CW'(FILT_CYC - 1)) begin
            filt_d = clean_q;
         end else begin
            cnt_d = cnt_q + CW'(1);
         end
      end
      level  = cfg.filt_on ? filt_q : clean_q;
      prev_d = level;
      req_d  = 1'b0;
      unique case (decode(cfg.mode))
         KIND_LOW:  req_d = ~level;
         KIND_HIGH: req_d = level;
         KIND_FALL: req_d = prev_q & ~level;
         KIND_RISE: req_d = ~prev_q & level;
         KIND_BOTH: req_d = prev_q ^ level;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sync_q  <= 3'h0;
         clean_q <= 1'b0;
         filt_q  <= 1'b0;
         cnt_q   <= '0;
         prev_q  <= 1'b0;
         req_q   <= 1'b0;
      end else begin
         sync_q  <= sync_d;
         clean_q <= clean_d;
         filt_q  <= filt_d;
         cnt_q   <= cnt_d;
         prev_q  <= prev_d;
         req_q   <= req_d;
      end
   end

   assign cfg.req = req_q;
endmodule

// File: design/ext_trig_ctrl.sv
// external interrupt trigger controller with wishbone register slave
//
// What this block does
// - three-bit field selects level or edge trigger
// - lines eight-fifteen have filter enable above field
// - first register holds lines zero-seven nibble steps
// - second register holds lines eight-fifteen nibble steps
// - all control registers reset to zero
`timescale 1ns/1ps
`include "ext_trig_map.svh"
module ext_trig_ctrl #(
   parameter int LINES    = 16,
   parameter int FILT_CYC = `EXT_FILT_CYC
) (
   input  wire logic                core_clk,
   input  wire logic                rst_b,
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire ext_trig_pkg::word_t wb_adr_i,
   input  wire logic [3:0]          wb_sel_i,
   input  wire ext_trig_pkg::word_t wb_dat_i,
   output      ext_trig_pkg::word_t wb_dat_o,
   output      logic                wb_ack_o,
   input  wire logic [LINES-1:0]    ext_pin,
   output      logic                irq
);
   import ext_trig_pkg::*;

   function automatic word_t merge(input word_t old, input word_t nw, input logic [3:0] sel);
      word_t r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   ///////////////////////////////////////////////////////////////////////////
   // bus slave: ack one cycle after request, write at the ack edge
   word_t            cfg_low_q,  cfg_low_d;
   word_t            cfg_mid_q,  cfg_mid_d;
   word_t            cfg_high_q, cfg_high_d;
   logic [LINES-1:0] stat_q,     stat_d;
   logic [LINES-1:0] en_q,       en_d;
   logic             ack_q,      ack_d;
   word_t            dat_q,      dat_d;
   logic [LINES-1:0] line_req;
   logic [LINES-1:0] clr;
   logic             req;
   logic             wr;
   word_t            wmask_en;
   word_t            en_wr;

   assign req = wb_cyc_i & wb_stb_i;
   assign wr  = req & wb_we_i & ack_q;

   always_comb begin
      ack_d = req & ~ack_q;
      dat_d = dat_q;
      if (req & ~ack_q & ~wb_we_i) begin
         unique case (wb_adr_i)
            `EXT_CFG_LOW_ADR:  dat_d = cfg_low_q;
            `EXT_CFG_MID_ADR:  dat_d = cfg_mid_q;
            `EXT_CFG_HIGH_ADR: dat_d = cfg_high_q;
            `EXT_IRQ_STAT_ADR: dat_d = word_t'(stat_q);
            `EXT_IRQ_EN_ADR:   dat_d = word_t'(en_q);
            default:           dat_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         ack_q <= ack_d;
         dat_q <= dat_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   ///////////////////////////////////////////////////////////////////////////
   // trigger configuration registers
   always_comb begin
      cfg_low_d  = cfg_low_q;
      cfg_mid_d  = cfg_mid_q;
      cfg_high_d = cfg_high_q;
      if (wr && wb_adr_i == `EXT_CFG_LOW_ADR) begin
         cfg_low_d = merge(cfg_low_q, wb_dat_i, wb_sel_i) & `EXT_CFG_LOW_MASK;
      end
      if (wr && wb_adr_i == `EXT_CFG_MID_ADR) begin
         cfg_mid_d = merge(cfg_mid_q, wb_dat_i, wb_sel_i);
      end
      if (wr && wb_adr_i == `EXT_CFG_HIGH_ADR) begin
         cfg_high_d = merge(cfg_high_q, wb_dat_i, wb_sel_i);
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_low_q  <= `EXT_CFG_RST;
         cfg_mid_q  <= `EXT_CFG_RST;
         cfg_high_q <= `EXT_CFG_RST;
      end else begin
         cfg_low_q  <= cfg_low_d;
         cfg_mid_q  <= cfg_mid_d;
         cfg_high_q <= cfg_high_d;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // per-line detectors
   line_cfg_if lc [LINES] ();

   for (genvar i = 0; i < LINES; i++) begin : g_line
      if (i < 8) begin : g_low
         assign lc[i].mode    = cfg_low_q[`EXT_FIELD_STEP*i +: 3];
         assign lc[i].filt_on = 1'b0;
      end else begin : g_mid
         assign lc[i].mode    = cfg_mid_q[`EXT_FIELD_STEP*(i-8) +: 3];
         assign lc[i].filt_on = cfg_mid_q[`EXT_FIELD_STEP*(i-8) + `EXT_FILT_BIT];
      end
      assign line_req[i] = lc[i].req;
      trig_line_detect #(
         .FILT_CYC (FILT_CYC)
      ) u_det (
         .core_clk (core_clk),
         .rst_b    (rst_b),
         .pin      (ext_pin[i]),
         .cfg      (lc[i])
      );
   end

   ///////////////////////////////////////////////////////////////////////////
   // sticky status, write-one clear, enable; a new request beats the clear
   assign wmask_en = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
   assign clr      = (wr && wb_adr_i == `EXT_IRQ_CLR_ADR) ? wmask_en[LINES-1:0] : '0;

   always_comb begin
      stat_d = (stat_q & ~clr) | line_req;
      en_d   = en_q;
      en_wr  = merge(word_t'(en_q), wb_dat_i, wb_sel_i);
      if (wr && wb_adr_i == `EXT_IRQ_EN_ADR) begin
         en_d = en_wr[LINES-1:0];
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         stat_q <= `EXT_IRQ_RST;
         en_q   <= `EXT_IRQ_RST;
      end else begin
         stat_q <= stat_d;
         en_q   <= en_d;
      end
   end

   assign irq = |(stat_q & en_q);
endmodule

// File: dv/ext_src_model.sv
// external interrupt source model driving the trigger pins
`timescale 1ns/1ps
module ext_src_model (
   input  wire logic        core_clk,
   output      logic [15:0] ext_pin
);
   initial ext_pin = 16'hffff;
   // each level is held whole cycles, never under 40ns
   task automatic drive(input logic [15:0] v, input int n);
      ext_pin <= v;
      repeat (n) @(posedge core_clk);
   endtask
endmodule

// File: dv/ext_trig_ctrl_asserts.sv
// bus and register checks for the trigger controller
`timescale 1ns/1ps
`include "ext_trig_map.svh"
module ext_trig_ctrl_asserts #(
   parameter int LINES    = 16,
   parameter int FILT_CYC = 1
) (
   input wire logic                core_clk,
   input wire logic                rst_b,
   input wire logic                wb_cyc_i,
   input wire logic                wb_stb_i,
   input wire logic                wb_we_i,
   input wire ext_trig_pkg::word_t wb_adr_i,
   input wire logic [3:0]          wb_sel_i,
   input wire ext_trig_pkg::word_t wb_dat_i,
   input wire ext_trig_pkg::word_t wb_dat_o,
   input wire logic                wb_ack_o,
   input wire logic [LINES-1:0]    ext_pin,
   input wire logic                irq
);
   import ext_trig_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   wire rd = wb_ack_o && !wb_we_i;
   ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   low_reserved_a: assert property (
      rd && wb_adr_i == `EXT_CFG_LOW_ADR |-> (wb_dat_o & ~`EXT_CFG_LOW_MASK) == 0)
      else $error("reserved bits set");
   unmapped_zero_a: assert property (rd && !(wb_adr_i inside {`EXT_CFG_LOW_ADR,
      `EXT_CFG_MID_ADR, `EXT_CFG_HIGH_ADR, `EXT_IRQ_STAT_ADR, `EXT_IRQ_EN_ADR})
      |-> wb_dat_o == 0) else $error("unmapped read not zero");
   stat_width_a: assert property (rd && wb_adr_i == `EXT_IRQ_STAT_ADR |-> wb_dat_o[31:16] == 0)
      else $error("status upper bits set");
   irq_fall_a: assert property ($fell(irq) |->
      $past(wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i, 2))
      else $error("irq dropped without write");
   ack_quiet_a: assert property (!wb_cyc_i ##1 !wb_cyc_i |-> !wb_ack_o)
      else $error("ack while idle");
endmodule
bind ext_trig_ctrl ext_trig_ctrl_asserts #(.LINES(LINES), .FILT_CYC(FILT_CYC))
   ext_trig_ctrl_asserts_i (.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_pin(ext_pin),
   .irq(irq));

// File: dv/tb_top.sv
// self-checking bench for the external trigger controller
`timescale 1ns/1ps
`include "ext_trig_map.svh"
module tb_top;
   import ext_trig_pkg::*;
   typedef struct {word_t adr; word_t wd; word_t exp;} row_s;
   logic        core_clk = 0;
   logic        rst_b = 0;
   logic        cyc = 0, stb = 0, we = 0, ack, irq;
   logic [3:0]  sel = 4'hf;
   logic [15:0] pins;
   word_t       adr = '0, wd = '0, rdat, rv;
   int          errors = 0, cmp_count = 0, cyc_n = 0;
   row_s        rows[6];
   always #50 core_clk = ~core_clk;
   ext_src_model ext_src_model_i (.core_clk(core_clk), .ext_pin(pins));
   ext_trig_ctrl #(.FILT_CYC(3)) ext_trig_ctrl_i (.core_clk(core_clk), .rst_b(rst_b),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .ext_pin(pins), .irq(irq));
   task automatic chk(input string nm, input word_t e, input word_t g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chk_irq(input string nm, input logic e);
      repeat (2) @(posedge core_clk);
      chk(nm, {31'h0, e}, {31'h0, irq});
   endtask
   task automatic bus(input logic w, input word_t a, input word_t d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      wd  <= d;
      do @(posedge core_clk); while (ack !== 1'b1);
      rv = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic stat(input string nm, input logic hit, input word_t b);
      bus(1'b0, `EXT_IRQ_STAT_ADR, '0);
      chk(nm, hit ? b : '0, rv);
      bus(1'b1, `EXT_IRQ_CLR_ADR, 32'hffff);
   endtask
   task automatic mode_run(input int ln, input logic [2:0] m);
      word_t b;
      b = word_t'(1) << ln;
      if (ln == 0) bus(1'b1, `EXT_CFG_LOW_ADR, {29'h0, m});
      else bus(1'b1, `EXT_CFG_MID_ADR, {24'h0, 1'b1, m, 4'h0});
      repeat (10) @(posedge core_clk);
      bus(1'b1, `EXT_IRQ_CLR_ADR, 32'hffff);
      repeat (10) @(posedge core_clk);
      stat("steady high", m == 3'b001, b);
      ext_src_model_i.drive(~b[15:0], 10);
      stat("fall", m[2:1] != 2'b10, b);
      repeat (10) @(posedge core_clk);
      stat("steady low", m == 3'b000, b);
      ext_src_model_i.drive(16'hffff, 10);
      stat("rise", m[2:1] != 2'b01, b);
   endtask
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 8000) begin
         errors++;
         wrap_up();
      end
   end
   initial begin
      rows = '{'{`EXT_CFG_LOW_ADR, 32'hffff_ffff, `EXT_CFG_LOW_MASK},
               '{`EXT_CFG_MID_ADR, 32'hffff_ffff, 32'hffff_ffff},
               '{`EXT_CFG_HIGH_ADR, 32'ha5a5_5a5a, 32'ha5a5_5a5a},
               '{`EXT_IRQ_EN_ADR, 32'hffff_ffff, 32'h0000_ffff},
               '{`EXT_IRQ_CLR_ADR, 32'hffff_ffff, 32'h0},
               '{32'h5600_0094, 32'hffff_ffff, 32'h0}};
      repeat (4) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      foreach (rows[i]) begin
         bus(1'b0, rows[i].adr, '0);
         chk("reset value", `EXT_CFG_RST, rv);
         bus(1'b1, rows[i].adr, rows[i].wd);
         bus(1'b0, rows[i].adr, '0);
         chk("readback", rows[i].exp, rv);
      end
      $display("register table done");
      bus(1'b1, `EXT_IRQ_EN_ADR, '0);
      for (int k = 0; k < 16; k++) mode_run((k < 8) ? 0 : 9, k[2:0]);
      $display("trigger modes done");
      // line eight unfiltered, line nine filtered, both low level
      bus(1'b1, `EXT_CFG_MID_ADR, 32'h80);
      repeat (10) @(posedge core_clk);
      bus(1'b1, `EXT_IRQ_CLR_ADR, 32'hffff);
      ext_src_model_i.drive(16'hfcff, 2);
      ext_src_model_i.drive(16'hffff, 10);
      stat("short pulse", 1'b1, 32'h100);
      ext_src_model_i.drive(16'hfdff, 8);
      ext_src_model_i.drive(16'hffff, 10);
      stat("long pulse", 1'b1, 32'h200);
      $display("filter done");
      bus(1'b1, `EXT_CFG_LOW_ADR, 32'h2);
      bus(1'b1, `EXT_IRQ_EN_ADR, 32'h1);
      ext_src_model_i.drive(16'hfffe, 10);
      chk_irq("irq raised", 1'b1);
      bus(1'b1, `EXT_IRQ_EN_ADR, 32'h0);
      chk_irq("irq masked", 1'b0);
      bus(1'b1, `EXT_IRQ_EN_ADR, 32'h1);
      chk_irq("irq unmasked", 1'b1);
      bus(1'b1, `EXT_IRQ_CLR_ADR, 32'h1);
      chk_irq("irq cleared", 1'b0);
      $display("interrupt done");
      sel <= 4'h1;
      bus(1'b1, `EXT_CFG_HIGH_ADR, 32'hffff_ffff);
      sel <= 4'hf;
      bus(1'b0, `EXT_CFG_HIGH_ADR, '0);
      chk("byte select", 32'ha5a5_5aff, rv);
      $display("byte select done");
      bus(1'b1, `EXT_CFG_LOW_ADR, '0);
      chk_irq("irq low level", 1'b1);
      // reset in mid-run, with a live interrupt
      rst_b <= 1'b0;
      chk_irq("irq in reset", 1'b0);
      rst_b <= 1'b1;
      @(posedge core_clk);
      foreach (rows[i]) begin
         bus(1'b0, rows[i].adr, '0);
         chk("reset again", `EXT_CFG_RST, rv);
      end
      chk_irq("irq after reset", 1'b0);
      $display("reset done");
      wrap_up();
   end
endmodule
